// ### logic/dew_guard.v
// dew_guard.v: apb register front end and write protection of the data
// memory, plus a programmer access port that honours code protection.
// assumes: apb master on clk; rst_n is the power-on reset; the
// programmer port runs on clk; the protect strap may come from anywhere.
//
// Summary of operation
// - power-on reset clears the write permit bit
// - no write start while power-up timer runs
// - start needs permit plus unlock just before
// - code protect blocks all programmer port accesses
// - core access works regardless of code protect
// - each address selects exactly one byte
// - unimplemented register bits read as zero
// - write end clears start, sets complete flag
// - busy freezes address, data and control; permit and start separate
// - read result lands in data two cycles after the read command
`timescale 1ns/10ps
`default_nettype none
`include "dew_map.vh"

module dew_guard #(
  parameter [19:0] PWRT_CYCLES = `DEW_PWRT_CYCLES,
  parameter [19:0] WRITE_CYCLES = `DEW_WRITE_CYCLES
) (
  input wire clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata_q,
  output reg pready_q,
  output reg pslverr_q,
  output reg irq_q,
  input wire code_protect,
  input wire ext_req,
  input wire ext_we,
  input wire [`DEW_ADDR_W-1:0] ext_addr,
  input wire [7:0] ext_wdata,
  output wire [7:0] ext_rdata,
  output reg ext_ack_q,
  output reg ext_denied_q
);

  // ========================================================================
  // unlock tracker states
  localparam [1:0] UL_IDLE = 2'b00;
  localparam [1:0] UL_FIRST = 2'b01;
  localparam [1:0] UL_ARMED = 2'b10;

  // register index codes
  localparam [2:0] IX_ADDR_LO = 3'd0;
  localparam [2:0] IX_ADDR_HI = 3'd1;
  localparam [2:0] IX_DATA = 3'd2;
  localparam [2:0] IX_UNLOCK = 3'd3;
  localparam [2:0] IX_CTRL = 3'd4;
  localparam [2:0] IX_STATUS = 3'd5;
  localparam [2:0] IX_MASK = 3'd6;
  localparam [2:0] IX_NONE = 3'd7;

  // map a byte address to a register index, IX_NONE when unmapped
  function [2:0] reg_idx;
    input [7:0] a;
    begin
      case (a)
        `DEW_OFF_ADDR_LO: reg_idx = IX_ADDR_LO;
        `DEW_OFF_ADDR_HI: reg_idx = IX_ADDR_HI;
        `DEW_OFF_DATA: reg_idx = IX_DATA;
        `DEW_OFF_UNLOCK: reg_idx = IX_UNLOCK;
        `DEW_OFF_CTRL: reg_idx = IX_CTRL;
        `DEW_OFF_STATUS: reg_idx = IX_STATUS;
        `DEW_OFF_MASK: reg_idx = IX_MASK;
        default: reg_idx = IX_NONE;
      endcase
    end
  endfunction

  reg [7:0] addr_lo_q;
  reg [`DEW_ADDR_HI_W-1:0] addr_hi_q;
  reg [7:0] data_q;
  reg pgm_sel_q;
  reg cfg_sel_q;
  reg err_q;
  reg permit_q;
  reg busy_q;
  reg rd_pend_q;
  reg flag_q;
  reg mask_q;
  reg [1:0] ul_q;
  reg [1:0] ul_d;
  reg [19:0] pwrt_cnt_q;
  reg pwrt_done_q;
  reg [19:0] wr_cnt_q;
  reg cp_meta_q;
  reg cp_sync_q;
  reg [31:0] rd_mux;

  wire xfer;
  wire wr_xfer;
  wire [2:0] idx_xfer;
  wire [2:0] idx_req;
  wire ctrl_wr;
  wire data_space;
  wire unlock_ok;
  wire wr_start;
  wire wr_refused;
  wire rd_start;
  wire wr_done;
  wire int_op;
  wire ext_go;
  wire mem_we;
  wire mem_re;
  wire [`DEW_ADDR_W-1:0] mem_addr;
  wire [7:0] mem_wdata;
  wire [7:0] mem_rdata;

  // ========================================================================
  // apb handshake: one wait state so read data comes from a flop
  assign xfer = psel & penable & pready_q;
  assign wr_xfer = xfer & pwrite;
  assign idx_xfer = reg_idx(paddr);
  assign idx_req = reg_idx(paddr);

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end
    else if (psel & penable & ~pready_q)
    begin
      pready_q <= 1'b1;
      pslverr_q <= (idx_req == IX_NONE);
      prdata_q <= pwrite ? 32'h00000000 : rd_mux;
    end
    else
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // read mux, every bit that is not held reads as zero
  always @*
  begin
    rd_mux = 32'h00000000;
    case (idx_req)
      IX_ADDR_LO: rd_mux = {24'h000000, addr_lo_q};
      IX_ADDR_HI: rd_mux = {30'h00000000, addr_hi_q};
      IX_DATA: rd_mux = {24'h000000, data_q};
      IX_UNLOCK: rd_mux = 32'h00000000; // no storage behind it
      IX_CTRL: rd_mux = {24'h000000, pgm_sel_q, cfg_sel_q, 2'b00,
                         err_q, permit_q, busy_q, rd_pend_q};
      IX_STATUS: rd_mux = {31'h00000000, flag_q};
      IX_MASK: rd_mux = {31'h00000000, mask_q};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // ========================================================================
  // power-up timer: counts once from power-on, then stays done
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      pwrt_cnt_q <= 20'h00000;
      pwrt_done_q <= 1'b0;
    end
    else if (!pwrt_done_q)
    begin
      pwrt_cnt_q <= pwrt_cnt_q + 20'h00001;
      if (pwrt_cnt_q == PWRT_CYCLES - 20'h00001)
        pwrt_done_q <= 1'b1;
    end
  end

  // ========================================================================
  // unlock tracker: only the ordered key pair arms it; any other access
  // disarms, so a stray write between keys and start kills the attempt
  always @*
  begin
    ul_d = ul_q;
    if (xfer)
    begin
      if (wr_xfer && idx_xfer == IX_UNLOCK)
      begin
        if (pwdata[7:0] == `DEW_KEY_FIRST)
          ul_d = UL_FIRST;
        else if (pwdata[7:0] == `DEW_KEY_SECOND && ul_q == UL_FIRST)
          ul_d = UL_ARMED;
        else
          ul_d = UL_IDLE;
      end
      else
        ul_d = UL_IDLE;
    end
  end

  always @(posedge clk)
  begin
    if (!rst_n)
      ul_q <= UL_IDLE;
    else
    begin
      case (ul_d)
        UL_IDLE: ul_q <= UL_IDLE;
        UL_FIRST: ul_q <= UL_FIRST;
        UL_ARMED: ul_q <= UL_ARMED;
        default: ul_q <= UL_IDLE;
      endcase
    end
  end

  // ========================================================================
  // start decode; permit must already be set before this write
  assign ctrl_wr = wr_xfer & (idx_xfer == IX_CTRL) & ~busy_q;
  assign data_space = ~pwdata[`DEW_CTL_PGM] & ~pwdata[`DEW_CTL_CFG];
  assign unlock_ok = (ul_q == UL_ARMED) & permit_q;
  assign wr_start = ctrl_wr & pwdata[`DEW_CTL_START] & data_space
                    & unlock_ok & pwrt_done_q;
  assign wr_refused = ctrl_wr & pwdata[`DEW_CTL_START] & data_space
                      & unlock_ok & ~pwrt_done_q;
  assign rd_start = ctrl_wr & pwdata[`DEW_CTL_READ] & data_space
                    & ~pwdata[`DEW_CTL_START];
  assign wr_done = busy_q & (wr_cnt_q == WRITE_CYCLES - 20'h00001);

  // control bits; permit only changes by software and resets clear it
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      permit_q <= 1'b0;
      pgm_sel_q <= 1'b0;
      cfg_sel_q <= 1'b0;
      err_q <= 1'b0;
    end
    else
    begin
      if (ctrl_wr)
      begin
        permit_q <= pwdata[`DEW_CTL_PERMIT];
        pgm_sel_q <= pwdata[`DEW_CTL_PGM];
        cfg_sel_q <= pwdata[`DEW_CTL_CFG];
      end
      // refusal sets the error bit and wins over a software clear
      if (wr_refused)
        err_q <= 1'b1;
      else if (ctrl_wr && !pwdata[`DEW_CTL_ERR])
        err_q <= 1'b0;
    end
  end

  // ========================================================================
  // self-timed write: start bit is the busy flag until the end
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      busy_q <= 1'b0;
      wr_cnt_q <= 20'h00000;
    end
    else if (wr_start)
    begin
      busy_q <= 1'b1;
      wr_cnt_q <= 20'h00000;
    end
    else if (wr_done)
      busy_q <= 1'b0;
    else if (busy_q)
      wr_cnt_q <= wr_cnt_q + 20'h00001;
  end

  // ========================================================================
  // address and data registers, frozen while a write runs
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      addr_lo_q <= `DEW_RST_BYTE;
      addr_hi_q <= {`DEW_ADDR_HI_W{1'b0}};
      data_q <= `DEW_RST_BYTE;
      rd_pend_q <= 1'b0;
    end
    else
    begin
      rd_pend_q <= rd_start;
      if (wr_xfer && !busy_q && idx_xfer == IX_ADDR_LO)
        addr_lo_q <= pwdata[7:0];
      if (wr_xfer && !busy_q && idx_xfer == IX_ADDR_HI)
        addr_hi_q <= pwdata[`DEW_ADDR_HI_W-1:0];
      // a finished read overrides software, they cannot coincide anyway
      if (rd_pend_q)
        data_q <= mem_rdata;
      else if (wr_xfer && !busy_q && idx_xfer == IX_DATA)
        data_q <= pwdata[7:0];
    end
  end

  // ========================================================================
  // completion flag, write one to clear; a new event beats the clear
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      flag_q <= 1'b0;
      mask_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      if (wr_done)
        flag_q <= 1'b1;
      else if (wr_xfer && idx_xfer == IX_STATUS && pwdata[0])
        flag_q <= 1'b0;
      if (wr_xfer && idx_xfer == IX_MASK)
        mask_q <= pwdata[0];
      irq_q <= flag_q & mask_q;
    end
  end

  // ========================================================================
  // protect strap synchroniser; only the second stage is looked at
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      cp_meta_q <= 1'b1;
      cp_sync_q <= 1'b1;
    end
    else
    begin
      cp_meta_q <= code_protect;
      cp_sync_q <= cp_meta_q;
    end
  end

  // ========================================================================
  // memory arbitration: the core wins, the programmer is turned away
  // rather than queued, which keeps the port free of hidden state
  assign int_op = wr_start | rd_start;
  assign ext_go = ext_req & ~cp_sync_q & ~busy_q & ~int_op;
  assign mem_we = wr_start | (ext_go & ext_we);
  assign mem_re = rd_start | (ext_go & ~ext_we);
  // one byte per address, high and low parts concatenated
  assign mem_addr = int_op ? {addr_hi_q, addr_lo_q} : ext_addr;
  assign mem_wdata = int_op ? data_q : ext_wdata;
  assign ext_rdata = mem_rdata;

  // programmer answers, one cycle after the request
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      ext_ack_q <= 1'b0;
      ext_denied_q <= 1'b0;
    end
    else
    begin
      ext_ack_q <= ext_go;
      ext_denied_q <= ext_req & ~ext_go;
    end
  end

  dew_mem u_mem (
    .clk(clk),
    .rst_n(rst_n),
    .we(mem_we),
    .re(mem_re),
    .addr(mem_addr),
    .wdata(mem_wdata),
    .rdata_q(mem_rdata)
  );

endmodule // dew_guard
`default_nettype wire

// ### logic/dew_map.vh
// dew_map.vh: register offsets, control fields, keys and timing counts
// of the data memory write guard.
// assumes: included by bare name from the design files under logic/.
`ifndef DEW_MAP_VH
`define DEW_MAP_VH

// ==========================================================================
// register byte offsets on the apb bus
`define DEW_OFF_ADDR_LO 8'h00
`define DEW_OFF_ADDR_HI 8'h04
`define DEW_OFF_DATA 8'h08
`define DEW_OFF_UNLOCK 8'h0c
`define DEW_OFF_CTRL 8'h10
`define DEW_OFF_STATUS 8'h14
`define DEW_OFF_MASK 8'h18

// ==========================================================================
// control register fields
`define DEW_CTL_PGM 7
`define DEW_CTL_CFG 6
`define DEW_CTL_ERR 3
`define DEW_CTL_PERMIT 2
`define DEW_CTL_START 1
`define DEW_CTL_READ 0

// ==========================================================================
// widths, reset values and unlock keys
`define DEW_ADDR_W 10
`define DEW_ADDR_HI_W 2
`define DEW_RST_BYTE 8'h00
`define DEW_KEY_FIRST 8'h55
`define DEW_KEY_SECOND 8'haa

// ==========================================================================
// timing: times in their own unit; counts are for the 10 mhz clock and
// sized to the 20 bit counters so the parameter defaults lose no bits
`define DEW_CLK_KHZ 10000
`define DEW_PWRT_MS 72
`define DEW_WRITE_US 4000
`define DEW_PWRT_CYCLES 20'd720000
`define DEW_WRITE_CYCLES 20'd40000

`endif

// ### logic/dew_mem.v
// dew_mem.v: byte wide storage array with one registered read port.
// assumes: one access per cycle, arbitration is done by the caller.
`timescale 1ns/10ps
`default_nettype none
`include "dew_map.vh"

module dew_mem (
  input wire clk,
  input wire rst_n,
  input wire we,
  input wire re,
  input wire [`DEW_ADDR_W-1:0] addr,
  input wire [7:0] wdata,
  output reg [7:0] rdata_q
);

  reg [7:0] mem_q [0:(1<<`DEW_ADDR_W)-1];

  // ========================================================================
  // array write, no reset: contents are meant to survive a reset
  always @(posedge clk)
  begin
    if (we)
      mem_q[addr] <= wdata;
  end

  // registered read data, held until the next read
  always @(posedge clk)
  begin
    if (!rst_n)
      rdata_q <= `DEW_RST_BYTE;
    else if (re)
      rdata_q <= mem_q[addr];
  end

endmodule // dew_mem
`default_nettype wire

// ### bench/dew_guard_assertions.sv
// dew_guard_assertions.sv: bus and protection checks on dew_guard.
// assumes: bound to every dew_guard; one clock, reset rst_n.
`timescale 1ns/10ps
`default_nettype none
`include "dew_map.vh"

// ====================
// checker
module dew_guard_chk #(
  parameter [19:0] PWRT_CYCLES = 20,
  parameter [19:0] WRITE_CYCLES = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata_q,
  input wire logic pready_q,
  input wire logic pslverr_q,
  input wire logic code_protect,
  input wire logic ext_req,
  input wire logic ext_ack_q,
  input wire logic ext_denied_q
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // an access phase, then its single answer cycle
  sequence s_first;
    psel && penable && !pready_q;
  endsequence
  sequence s_done;
    pready_q ##1 !pready_q;
  endsequence
  // strap held long enough to pass the synchroniser
  sequence s_prot_req;
    code_protect [*4] ##0 ext_req;
  endsequence

  a_ready_one_wait: assert property (s_first |=> s_done)
    else $error("ready is not one pulse after access");
  a_no_stray_ready: assert property (!(psel && penable) |=> !pready_q)
    else $error("ready without access");
  a_unmapped_err: assert property (psel && penable && pready_q
    && paddr > `DEW_OFF_MASK |-> pslverr_q)
    else $error("unmapped access not flagged");
  a_mapped_ok: assert property (psel && penable && pready_q
    && paddr <= `DEW_OFF_MASK && paddr[1:0] == 2'b00 |-> !pslverr_q)
    else $error("mapped access flagged");
  a_unlock_zero: assert property (pready_q && !pwrite
    && paddr == `DEW_OFF_UNLOCK |-> prdata_q == 32'h0)
    else $error("unlock port read not zero");
  a_upper_zero: assert property (pready_q && psel && !pwrite
    |-> prdata_q[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_ext_refused: assert property (s_prot_req
    |=> ext_denied_q && !ext_ack_q)
    else $error("protected request not refused");
  a_ext_one_answer: assert property (ext_req
    |=> ext_ack_q != ext_denied_q)
    else $error("request without single answer");
  a_ext_quiet: assert property (!ext_req |=> !ext_ack_q && !ext_denied_q)
    else $error("answer without request");
endmodule // dew_guard_chk

bind dew_guard dew_guard_chk #(
  .PWRT_CYCLES(PWRT_CYCLES),
  .WRITE_CYCLES(WRITE_CYCLES)
) u_chk (
  .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata_q(prdata_q),
  .pready_q(pready_q), .pslverr_q(pslverr_q),
  .code_protect(code_protect), .ext_req(ext_req),
  .ext_ack_q(ext_ack_q), .ext_denied_q(ext_denied_q)
);
`default_nettype wire

// ### bench/dew_prog_model.sv
// dew_prog_model.sv: external programmer issuing one-cycle requests.
// assumes: go is a one-cycle pulse from the bench on clk.
`timescale 1ns/10ps
`default_nettype none

// ====================
// programmer model
module dew_prog_model (
  input wire logic clk,
  input wire logic go,
  input wire logic go_we,
  input wire logic [9:0] go_addr,
  input wire logic [7:0] go_data,
  output logic ext_req,
  output logic ext_we,
  output logic [9:0] ext_addr,
  output logic [7:0] ext_wdata
);
  initial
  begin
    ext_req = 1'b0;
    ext_we = 1'b0;
    ext_addr = 10'h0;
    ext_wdata = 8'h0;
  end
  // released lines flip so a stale value never looks valid
  always @(posedge clk)
  begin
    ext_req <= go;
    if (go)
    begin
      ext_we <= go_we;
      ext_addr <= go_addr;
      ext_wdata <= go_data;
    end
    else if (ext_req)
    begin
      ext_we <= ~ext_we;
      ext_addr <= ~ext_addr;
      ext_wdata <= ~ext_wdata;
    end
  end
endmodule // dew_prog_model
`default_nettype wire

// ### bench/tb_data_eeprom_write_guard.sv
// tb_data_eeprom_write_guard.sv: apb tests of the write guard.
// assumes: short power-up and write counts set by parameter.
`timescale 1ns/10ps
`default_nettype none
`include "dew_map.vh"

// ====================
// testbench
module tb_data_eeprom_write_guard;
  localparam [19:0] PWRT = 20'd100;
  localparam [19:0] WCYC = 20'd16;
  logic clk, rst_n, psel, penable, pwrite, code_protect, go, go_we, e;
  logic [7:0] paddr, go_data;
  logic [9:0] go_addr;
  logic [31:0] pwdata, r;
  integer mismatches, n_tests, k;
  wire [31:0] prdata_q;
  wire pready_q, pslverr_q, irq_q, ext_req, ext_we, ext_ack_q;
  wire ext_denied_q;
  wire [9:0] ext_addr;
  wire [7:0] ext_wdata, ext_rdata;

  dew_guard #(.PWRT_CYCLES(PWRT), .WRITE_CYCLES(WCYC)) DUT (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
    .irq_q(irq_q), .code_protect(code_protect), .ext_req(ext_req),
    .ext_we(ext_we), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
    .ext_rdata(ext_rdata), .ext_ack_q(ext_ack_q),
    .ext_denied_q(ext_denied_q));
  dew_prog_model u_prog (.clk(clk), .go(go), .go_we(go_we),
    .go_addr(go_addr), .go_data(go_data), .ext_req(ext_req),
    .ext_we(ext_we), .ext_addr(ext_addr), .ext_wdata(ext_wdata));

  // 10 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task summarize;
  begin
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask

  task hang;
  begin
    mismatches = mismatches + 1;
    $display("[FAIL] %0t wait ran out", $time);
    summarize;
  end
  endtask

  task chk(input logic [31:0] g, input logic [31:0] x);
  begin
    n_tests = n_tests + 1;
    if (g !== x)
    begin
      mismatches = mismatches + 1;
      $display("[FAIL] %0t got %h expected %h", $time, g, x);
    end
  end
  endtask

  // one apb transfer; an idle edge after it keeps drivers single
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    integer i;
  begin
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge clk);
      if (pready_q === 1'b1)
        break;
    end
    if (i == 20)
      hang;
    r = prdata_q;
    e = pslverr_q;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask

  task rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  // address, data, permit, both keys, then start
  task nv_write(input logic [9:0] a, input logic [7:0] d);
  begin
    wr(`DEW_OFF_ADDR_LO, a[7:0]);
    wr(`DEW_OFF_ADDR_HI, {6'h0, a[9:8]});
    wr(`DEW_OFF_DATA, d);
    wr(`DEW_OFF_CTRL, 8'h04);
    wr(`DEW_OFF_UNLOCK, 8'h55);
    wr(`DEW_OFF_UNLOCK, 8'haa);
    wr(`DEW_OFF_CTRL, 8'h06);
  end
  endtask

  task nv_read(input logic [9:0] a);
  begin
    wr(`DEW_OFF_ADDR_LO, a[7:0]);
    wr(`DEW_OFF_ADDR_HI, {6'h0, a[9:8]});
    wr(`DEW_OFF_CTRL, 8'h01);
    rd(`DEW_OFF_DATA);
  end
  endtask

  // firmware polls the start bit until the write ends
  task wait_idle;
    integer i;
  begin
    for (i = 0; i < 40; i++)
    begin
      rd(`DEW_OFF_CTRL);
      if (r[1] === 1'b0)
        break;
    end
    if (i == 40)
      hang;
  end
  endtask

  // programmer request; r holds denied, ack and read byte
  task ext_op(input logic w, input logic [9:0] a, input logic [7:0] d);
    integer i;
  begin
    go <= 1'b1;
    go_we <= w;
    go_addr <= a;
    go_data <= d;
    @(posedge clk);
    go <= 1'b0;
    for (i = 0; i < 10; i++)
    begin
      @(posedge clk);
      if (ext_ack_q === 1'b1 || ext_denied_q === 1'b1)
        break;
    end
    if (i == 10)
      hang;
    r = {22'h0, ext_denied_q, ext_ack_q, ext_rdata};
  end
  endtask

  // main sequence
  initial
  begin
    mismatches = 0;
    n_tests = 0;
    {rst_n, psel, penable, pwrite, code_protect, go, go_we} = 7'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    go_addr = 10'h0;
    go_data = 8'h0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (k = 0; k < 7; k++)
    begin
      rd(8'(k * 4));
      chk(r, 32'h0);
    end
    rd(8'h1c);
    chk({31'h0, e}, 32'h1);
    $display("reset values done");
    nv_write(10'h2a5, 8'h3c);
    rd(`DEW_OFF_CTRL);
    chk(r, 32'h0c);
    repeat (PWRT) @(posedge clk);
    $display("power-up lock done");
    wr(`DEW_OFF_CTRL, 8'h00);
    wr(`DEW_OFF_UNLOCK, 8'h55);
    wr(`DEW_OFF_UNLOCK, 8'haa);
    wr(`DEW_OFF_CTRL, 8'h06);
    rd(`DEW_OFF_CTRL);
    chk(r & 32'h2, 32'h0);
    wr(`DEW_OFF_CTRL, 8'h04);
    wr(`DEW_OFF_UNLOCK, 8'h55);
    rd(`DEW_OFF_ADDR_LO);
    wr(`DEW_OFF_UNLOCK, 8'haa);
    wr(`DEW_OFF_CTRL, 8'h06);
    rd(`DEW_OFF_CTRL);
    chk(r & 32'h2, 32'h0);
    $display("start refusal done");
    wr(`DEW_OFF_MASK, 8'h01);
    nv_write(10'h2a5, 8'h3c);
    rd(`DEW_OFF_CTRL);
    chk(r, 32'h06);
    wr(`DEW_OFF_ADDR_LO, 8'h11);
    rd(`DEW_OFF_ADDR_LO);
    chk(r, 32'ha5);
    wait_idle;
    rd(`DEW_OFF_STATUS);
    chk(r, 32'h1);
    chk({31'h0, irq_q}, 32'h1);
    wr(`DEW_OFF_STATUS, 8'h01);
    @(posedge clk);
    chk({31'h0, irq_q}, 32'h0);
    nv_write(10'h2a6, 8'hc3);
    wait_idle;
    wr(`DEW_OFF_STATUS, 8'h01);
    $display("write cycle done");
    nv_read(10'h2a5);
    chk(r, 32'h3c);
    nv_read(10'h2a6);
    chk(r, 32'hc3);
    nv_write(10'h2a6, r[7:0]);
    wait_idle;
    wr(`DEW_OFF_STATUS, 8'h01);
    nv_read(10'h2a6);
    chk(r, 32'hc3);
    $display("read back done");
    ext_op(1'b0, 10'h2a5, 8'h00);
    chk(r, 32'h13c);
    ext_op(1'b1, 10'h2a7, 8'h5a);
    chk(r & 32'h300, 32'h100);
    nv_read(10'h2a7);
    chk(r, 32'h5a);
    code_protect <= 1'b1;
    repeat (4) @(posedge clk);
    ext_op(1'b1, 10'h2a5, 8'h5a);
    chk(r & 32'h300, 32'h200);
    ext_op(1'b0, 10'h2a5, 8'h00);
    chk(r & 32'h300, 32'h200);
    nv_read(10'h2a5);
    chk(r, 32'h3c);
    $display("protection done");
    // reset in mid-run: permit must fall, the timer must lock again
    wr(`DEW_OFF_CTRL, 8'h04);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(`DEW_OFF_CTRL);
    chk(r, 32'h0);
    nv_write(10'h2a5, 8'h77);
    rd(`DEW_OFF_CTRL);
    chk(r, 32'h0c);
    nv_read(10'h2a5);
    chk(r, 32'h3c);
    $display("second reset done");
    summarize;
  end
endmodule // tb_data_eeprom_write_guard
`default_nettype wire
